// file: hw/spg_pkg.sv
package spg_pkg;

   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [15:0] MGMT_CTRL_OFS  = 16'h5820;
   localparam logic [15:0] SMB_ADDR_OFS   = 16'h5824;
   localparam logic [15:0] POOL_STAT_OFS  = 16'h5828;

   // Field positions inside the management_control register.
   localparam int FILT_EN_LSB = 0;
   localparam int FILT_EN_MSB = 7;
   localparam int CSUM_BIT    = 8;
   localparam int RMCP2H_BIT  = 9;
   localparam int SHARED_BIT  = 10;
   localparam int FWD_EN_BIT  = 17;
   localparam int M2H_EN_BIT  = 21;

   // Values after reset and writable bit masks.
   localparam logic [31:0] MGMT_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] MGMT_CTRL_WMASK = 32'h0022_07FF;
   localparam logic [6:0]  SMB_ADDR0_RST   = 7'h49;
   localparam logic [6:0]  SMB_ADDR1_RST   = 7'h4A;

   // Fragment store sizing.
   localparam logic [7:0]  FRAG_MAX    = 8'hF0;
   localparam logic [7:0]  FRAG_DEF    = 8'h20;
   localparam logic [11:0] STORE_BYTES = 12'hC00;

   // Reserved port of remote management traffic.
   localparam logic [15:0] RMCP_PORT = 16'h026F;

   // Bus answer codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register selector codes.
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_CTRL = 2'h1;
   localparam logic [1:0] SEL_ADDR = 2'h2;
   localparam logic [1:0] SEL_STAT = 2'h3;

   typedef enum logic [1:0] {SPG_TXN_IDLE, SPG_TXN_ACK, SPG_TXN_NACK, SPG_TXN_IGNORE} spg_txn_t;
   typedef enum logic [1:0] {SPG_INIT_START, SPG_INIT_RUN, SPG_INIT_READY} spg_init_t;

endpackage

// file: hw/spg_buf_divide.sv
`timescale 1ns/1ns
// Counts how many fragment buffers of the given size fit in the fragment store.
module spg_buf_divide (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic [7:0]  divisor,
   output logic             done,
   output logic [11:0]      quotient
);
   logic [11:0] rem_q, rem_d;
   logic [11:0] quo_q, quo_d;
   logic        run_q, run_d;
   logic        done_q, done_d;

   // Repeated subtraction; the divisor is read from the cycle after start onward.
   always_comb
   begin
      rem_d  = rem_q;
      quo_d  = quo_q;
      run_d  = run_q;
      done_d = 1'b0;
      if (start)
      begin
         rem_d = spg_pkg::STORE_BYTES;
         quo_d = 12'h000;
         run_d = 1'b1;
      end
      else if (run_q)
      begin
         if (rem_q >= {4'h0, divisor})
         begin
            rem_d = rem_q - {4'h0, divisor};
            quo_d = quo_q + 12'h001;
         end
         else
         begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   // Registers of the divider.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         rem_q  <= 12'h000;
         quo_q  <= 12'h000;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         rem_q  <= rem_d;
         quo_q  <= quo_d;
         run_q  <= run_d;
         done_q <= done_d;
      end
   end

   assign done     = done_q;
   assign quotient = quo_q;
endmodule

// file: hw/spg_rx_filter.sv
`timescale 1ns/1ns
// Decides where a received packet goes, from the control register and packet facts.
module spg_rx_filter (
   input  wire logic [31:0] ctrl,
   input  wire logic [7:0]  filter_hit,
   input  wire logic        host_match,
   input  wire logic        is_udp,
   input  wire logic [15:0] dst_port,
   input  wire logic        csum_ok,
   output logic             mp_pass,
   output logic             host_pass
);
   logic filt_pass;
   logic rmcp_block;

   // Only enabled filters count; hits of disabled filters are ignored.
   assign filt_pass = |(filter_hit & ctrl[spg_pkg::FILT_EN_MSB:spg_pkg::FILT_EN_LSB]);
   // The master forward enable and the checksum filter both gate the controller path.
   assign mp_pass = ctrl[spg_pkg::FWD_EN_BIT] & filt_pass
                    & (~ctrl[spg_pkg::CSUM_BIT] | csum_ok);
   // Remote management traffic stays away from the OS when addresses are shared and RMCP to OS is clear.
   assign rmcp_block = is_udp & (dst_port == spg_pkg::RMCP_PORT)
                       & ctrl[spg_pkg::SHARED_BIT] & ~ctrl[spg_pkg::RMCP2H_BIT];
   // Filtered management traffic may also be copied to the OS.
   assign host_pass = (host_match | (ctrl[spg_pkg::M2H_EN_BIT] & filt_pass))
                      & ~rmcp_block;
endmodule

// file: hw/spg_gate.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
// Summary of operation
// - Bad or non pass-through image NACKs all commands to its own slave addresses.
// - Foreign slave addresses are ignored, never acknowledged.
// - Address resolution may assign slave addresses at runtime.
// - Shared addresses without RMCP to OS block port 623.
// - Configured but disabled filters forward nothing.
// - Master forward enable clear blocks all controller traffic.
// - Management-to-host enable copies filtered traffic to OS.
// - Full shared pool NACKs controller packet writes.
// - Fragments up to configured size, 240 max, default 32.
// - Init splits 3 KB store by fragment size.
// - Fragment takes whole buffer; overflow NACKs transaction.
// - Checksum filter drops packets with bad checksum from the controller path only.
module spg_gate (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        init_req,
   input  wire logic        image_valid,
   input  wire logic        image_passthru,
   input  wire logic [7:0]  cfg_frag_size,
   input  wire logic        arp_assign,
   input  wire logic        arp_slot,
   input  wire logic [6:0]  arp_addr,
   input  wire logic        smb_start,
   input  wire logic [6:0]  smb_addr,
   input  wire logic        smb_frag,
   input  wire logic [7:0]  smb_frag_len,
   input  wire logic        smb_stop,
   output logic             smb_ack,
   output logic             smb_nack,
   input  wire logic        buf_release,
   input  wire logic        pkt_valid,
   input  wire logic [7:0]  pkt_filter_hit,
   input  wire logic        pkt_host_match,
   input  wire logic        pkt_is_udp,
   input  wire logic [15:0] pkt_dst_port,
   input  wire logic        pkt_csum_ok,
   output logic             to_mp,
   output logic             to_host
);
   // Maps a byte address onto a register selector.
   function automatic logic [1:0] reg_sel(input logic [15:0] a);
      case (a)
         spg_pkg::MGMT_CTRL_OFS: reg_sel = spg_pkg::SEL_CTRL;
         spg_pkg::SMB_ADDR_OFS:  reg_sel = spg_pkg::SEL_ADDR;
         spg_pkg::POOL_STAT_OFS: reg_sel = spg_pkg::SEL_STAT;
         default:                reg_sel = spg_pkg::SEL_NONE;
      endcase
   endfunction

   logic [31:0]       ctrl_q, ctrl_d;
   logic [6:0]        addr0_q, addr0_d;
   logic [6:0]        addr1_q, addr1_d;
   logic [15:0]       awaddr_q, awaddr_d;
   logic [31:0]       wdata_q, wdata_d;
   logic [3:0]        wstrb_q, wstrb_d;
   logic              aw_have_q, aw_have_d;
   logic              w_have_q, w_have_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q, bresp_d;
   logic              rvalid_q, rvalid_d;
   logic [1:0]        rresp_q, rresp_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [31:0]       wmerge;
   spg_pkg::spg_init_t init_q, init_d;
   logic [7:0]        frag_q, frag_d;
   logic              pass_q, pass_d;
   logic [11:0]       nbuf_q, nbuf_d;
   logic [11:0]       used_q, used_d;
   spg_pkg::spg_txn_t txn_q, txn_d;
   logic              to_mp_q, to_host_q;
   logic              div_done;
   logic [11:0]       div_quo;
   logic              ready;
   logic              addr_hit;
   logic              smb_take;
   logic              rx_take;
   logic              rel;
   logic              mp_pass, host_pass;

   // Bus slave: address and data are held independently, then written together.
   always_comb
   begin
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      ctrl_d    = ctrl_q;
      addr0_d   = addr0_q;
      addr1_d   = addr1_q;
      for (int i = 0; i < 4; i++)
         wmerge[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : ctrl_q[i*8 +: 8];
      if (s_axi_awvalid && s_axi_awready)
      begin
         awaddr_d  = s_axi_awaddr;
         aw_have_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
         w_have_d = 1'b1;
      end
      if (aw_have_q && w_have_q && !bvalid_q)
      begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = spg_pkg::RESP_OKAY;
         case (reg_sel(awaddr_q))
            spg_pkg::SEL_CTRL:
               ctrl_d = (ctrl_q & ~spg_pkg::MGMT_CTRL_WMASK) | (wmerge & spg_pkg::MGMT_CTRL_WMASK);
            spg_pkg::SEL_ADDR:
            begin
               if (wstrb_q[0])
                  addr0_d = wdata_q[6:0];
               if (wstrb_q[1])
                  addr1_d = wdata_q[14:8];
            end
            spg_pkg::SEL_STAT: bresp_d = spg_pkg::RESP_OKAY;
            default:           bresp_d = spg_pkg::RESP_SLVERR;
         endcase
      end
      else if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      // Address resolution overrides a bus write in the same cycle.
      if (arp_assign && !arp_slot)
         addr0_d = arp_addr;
      if (arp_assign && arp_slot)
         addr1_d = arp_addr;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_d = 1'b1;
         rresp_d  = spg_pkg::RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            spg_pkg::SEL_CTRL: rdata_d = ctrl_q;
            spg_pkg::SEL_ADDR: rdata_d = {8'h00, frag_q, 1'b0, addr1_q, 1'b0, addr0_q};
            spg_pkg::SEL_STAT: rdata_d = {pass_q, ready, 2'h0, nbuf_q, 4'h0, used_q};
            default:
            begin
               rdata_d = 32'h0000_0000;
               rresp_d = spg_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
   end

   // Bus slave registers.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         awaddr_q  <= 16'h0000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= spg_pkg::RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= spg_pkg::RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
         ctrl_q    <= spg_pkg::MGMT_CTRL_RST;
         addr0_q   <= spg_pkg::SMB_ADDR0_RST;
         addr1_q   <= spg_pkg::SMB_ADDR1_RST;
      end
      else
      begin
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         ctrl_q    <= ctrl_d;
         addr0_q   <= addr0_d;
         addr1_q   <= addr1_d;
      end
   end

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   spg_buf_divide u_div (
      .core_clk (core_clk),
      .nrst     (nrst),
      .start    (init_q == spg_pkg::SPG_INIT_START),
      .divisor  (frag_q),
      .done     (div_done),
      .quotient (div_quo)
   );

   spg_rx_filter u_filt (
      .ctrl       (ctrl_q),
      .filter_hit (pkt_filter_hit),
      .host_match (pkt_host_match),
      .is_udp     (pkt_is_udp),
      .dst_port   (pkt_dst_port),
      .csum_ok    (pkt_csum_ok),
      .mp_pass    (mp_pass),
      .host_pass  (host_pass)
   );

   assign ready    = (init_q == spg_pkg::SPG_INIT_READY);
   assign addr_hit = (smb_addr == addr0_q) || (smb_addr == addr1_q);
   assign smb_take = smb_frag && (txn_q == spg_pkg::SPG_TXN_ACK) && ready
                     && (smb_frag_len <= frag_q) && (used_q < nbuf_q);
   assign rx_take  = pkt_valid && mp_pass && ready
                     && ((used_q + {11'h000, smb_take}) < nbuf_q);
   assign rel      = buf_release && (used_q != 12'h000);

   // Initialization, transaction gating and buffer pool accounting.
   always_comb
   begin
      init_d = init_q;
      frag_d = frag_q;
      pass_d = pass_q;
      nbuf_d = nbuf_q;
      used_d = used_q + {11'h000, smb_take} + {11'h000, rx_take} - {11'h000, rel};
      txn_d  = txn_q;
      case (init_q)
         spg_pkg::SPG_INIT_START:
         begin
            // Stored settings are captured here only, then held until re-initialization.
            pass_d = image_valid && image_passthru;
            if (cfg_frag_size == 8'h00)
               frag_d = spg_pkg::FRAG_DEF;
            else if (cfg_frag_size > spg_pkg::FRAG_MAX)
               frag_d = spg_pkg::FRAG_MAX;
            else
               frag_d = cfg_frag_size;
            used_d = 12'h000;
            init_d = spg_pkg::SPG_INIT_RUN;
         end
         spg_pkg::SPG_INIT_RUN:
         begin
            used_d = 12'h000;
            if (div_done)
            begin
               nbuf_d = div_quo;
               init_d = spg_pkg::SPG_INIT_READY;
            end
         end
         spg_pkg::SPG_INIT_READY:
            if (init_req)
               init_d = spg_pkg::SPG_INIT_START;
         default: init_d = spg_pkg::SPG_INIT_START;
      endcase
      case (txn_q)
         spg_pkg::SPG_TXN_ACK:
            if (smb_stop)
               txn_d = spg_pkg::SPG_TXN_IDLE;
            else if (smb_frag && !smb_take)
               txn_d = spg_pkg::SPG_TXN_NACK;
         spg_pkg::SPG_TXN_IDLE, spg_pkg::SPG_TXN_NACK, spg_pkg::SPG_TXN_IGNORE:
            if (smb_stop)
               txn_d = spg_pkg::SPG_TXN_IDLE;
         default: txn_d = spg_pkg::SPG_TXN_IDLE;
      endcase
      if (smb_start)
      begin
         if (!addr_hit)
            txn_d = spg_pkg::SPG_TXN_IGNORE;
         else if (!pass_q || !ready)
            txn_d = spg_pkg::SPG_TXN_NACK;
         else
            txn_d = spg_pkg::SPG_TXN_ACK;
      end
   end

   // Registers of initialization, transactions and routing outputs.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         init_q    <= spg_pkg::SPG_INIT_START;
         frag_q    <= spg_pkg::FRAG_DEF;
         pass_q    <= 1'b0;
         nbuf_q    <= 12'h000;
         used_q    <= 12'h000;
         txn_q     <= spg_pkg::SPG_TXN_IDLE;
         to_mp_q   <= 1'b0;
         to_host_q <= 1'b0;
      end
      else
      begin
         init_q    <= init_d;
         frag_q    <= frag_d;
         pass_q    <= pass_d;
         nbuf_q    <= nbuf_d;
         used_q    <= used_d;
         txn_q     <= txn_d;
         to_mp_q   <= rx_take;
         to_host_q <= pkt_valid && host_pass;
      end
   end

   assign smb_ack  = (txn_q == spg_pkg::SPG_TXN_ACK);
   assign smb_nack = (txn_q == spg_pkg::SPG_TXN_NACK);
   assign to_mp    = to_mp_q;
   assign to_host  = to_host_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_no_image_nack;
      smb_start && addr_hit && !pass_q |=> smb_nack && !smb_ack;
   endproperty
   a_no_image_nack: assert property (p_no_image_nack)
      else $error("disabled pass-through did not NACK");
   property p_foreign_ignored;
      smb_start && !addr_hit |=> !smb_ack && !smb_nack;
   endproperty
   a_foreign_ignored: assert property (p_foreign_ignored)
      else $error("foreign address was answered");
   property p_arp_assign;
      arp_assign && !arp_slot |=> addr0_q == $past(arp_addr);
   endproperty
   a_arp_assign: assert property (p_arp_assign)
      else $error("resolved address not taken");
   property p_rmcp_block;
      pkt_valid && pkt_is_udp && pkt_dst_port == spg_pkg::RMCP_PORT
      && ctrl_q[spg_pkg::SHARED_BIT] && !ctrl_q[spg_pkg::RMCP2H_BIT] |=> !to_host;
   endproperty
   a_rmcp_block: assert property (p_rmcp_block)
      else $error("reserved port packet reached the OS");
   property p_disabled_filters;
      pkt_valid && (pkt_filter_hit & ctrl_q[7:0]) == 8'h00 |=> !to_mp;
   endproperty
   a_disabled_filters: assert property (p_disabled_filters)
      else $error("disabled filter forwarded a packet");
   property p_fwd_master;
      !ctrl_q[spg_pkg::FWD_EN_BIT] |=> !to_mp;
   endproperty
   a_fwd_master: assert property (p_fwd_master)
      else $error("packet forwarded with master enable clear");
   property p_m2h_copy;
      pkt_valid && ctrl_q[spg_pkg::M2H_EN_BIT] && (pkt_filter_hit & ctrl_q[7:0]) != 8'h00
      && !pkt_is_udp |=> to_host;
   endproperty
   a_m2h_copy: assert property (p_m2h_copy)
      else $error("filtered packet not copied to the OS");
   property p_pool_full_nack;
      smb_frag && smb_ack && !smb_start && !smb_stop && used_q == nbuf_q |=> smb_nack;
   endproperty
   a_pool_full_nack: assert property (p_pool_full_nack)
      else $error("write accepted into a full pool");
   property p_frag_size;
      smb_frag && smb_ack && !smb_start && !smb_stop && smb_frag_len > frag_q |=> smb_nack;
   endproperty
   a_frag_size: assert property (p_frag_size)
      else $error("oversized fragment accepted");
   property p_partition;
      $rose(ready) |-> nbuf_q == 12'(spg_pkg::STORE_BYTES / {4'h0, frag_q});
   endproperty
   a_partition: assert property (p_partition)
      else $error("store partition count wrong");
   property p_pool_bound;
      used_q <= nbuf_q;
   endproperty
   a_pool_bound: assert property (p_pool_bound)
      else $error("more buffers used than exist");
   property p_csum_drop;
      pkt_valid && ctrl_q[spg_pkg::CSUM_BIT] && !pkt_csum_ok |=> !to_mp;
   endproperty
   a_csum_drop: assert property (p_csum_drop)
      else $error("bad checksum packet forwarded");
   property p_frag_fixed;
      ready && !init_req |=> $stable(frag_q) && $stable(nbuf_q);
   endproperty
   a_frag_fixed: assert property (p_frag_fixed)
      else $error("fragment setting changed without init");
endmodule

// file: test/spg_mp_model.sv
`timescale 1ns/1ns
// Management processor stand-in that drives the SMBus side of the gate.
module spg_mp_model (
   input  wire logic core_clk,
   output logic       smb_start,
   output logic [6:0] smb_addr,
   output logic       smb_frag,
   output logic [7:0] smb_frag_len,
   output logic       smb_stop,
   output logic       buf_release,
   output logic       arp_assign,
   output logic       arp_slot,
   output logic [6:0] arp_addr
);
   // All strobes idle at time zero.
   initial
   begin
      {smb_start, smb_frag, smb_stop, buf_release, arp_assign} = 5'h00;
      {smb_addr, smb_frag_len, arp_slot, arp_addr} = 23'h000000;
   end

   // One strobe per call with its payload; the payload turns to junk once released.
   task automatic drive(input logic [4:0] s, input logic [7:0] d);
      @(posedge core_clk);
      {smb_start, smb_frag, smb_stop} <= s[4:2];
      buf_release <= s[1];
      arp_assign <= s[0];
      {smb_addr, arp_addr, arp_slot} <= {d[6:0], d[6:0], d[7]};
      smb_frag_len <= d;
      @(posedge core_clk);
      {smb_start, smb_frag, smb_stop, buf_release, arp_assign} <= 5'h00;
      {smb_addr, arp_addr, arp_slot} <= ~{d[6:0], d[6:0], d[7]};
      smb_frag_len <= ~d;
      repeat ($urandom % 3) @(posedge core_clk);
   endtask
endmodule

// file: test/spg_gate_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module spg_gate_tb;
   localparam logic [4:0]  ST  = 5'h10;
   localparam logic [4:0]  FR  = 5'h08;
   localparam logic [4:0]  SP  = 5'h04;
   localparam logic [4:0]  RL  = 5'h02;
   localparam logic [4:0]  AS  = 5'h01;
   localparam logic [33:0] ACK = 34'h3_0000_0002;
   localparam logic [33:0] NAK = 34'h3_0000_0001;
   logic        core_clk, nrst, init_req, image_valid, image_passthru, arp_assign, arp_slot;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        smb_start, smb_frag, smb_stop, smb_ack, smb_nack, buf_release, pkt_valid;
   logic        pkt_host_match, pkt_is_udp, pkt_csum_ok, to_mp, to_host, rchk;
   logic [15:0] s_axi_awaddr, s_axi_araddr, pkt_dst_port;
   logic [31:0] s_axi_wdata, s_axi_rdata, ctl, rd_d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, sp;
   logic [7:0]  cfg_frag_size, smb_frag_len, pkt_filter_hit;
   logic [6:0]  arp_addr, smb_addr;
   logic [33:0] q[$];
   int          error_cnt, compares, cyc, used, nb;

   spg_gate u_spg_gate (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .init_req, .image_valid,
      .image_passthru, .cfg_frag_size, .arp_assign, .arp_slot, .arp_addr, .smb_start,
      .smb_addr, .smb_frag, .smb_frag_len, .smb_stop, .smb_ack, .smb_nack, .buf_release,
      .pkt_valid, .pkt_filter_hit, .pkt_host_match, .pkt_is_udp, .pkt_dst_port,
      .pkt_csum_ok, .to_mp, .to_host);
   spg_mp_model u_spg_mp_model (.core_clk, .smb_start, .smb_addr, .smb_frag, .smb_frag_len,
      .smb_stop, .buf_release, .arp_assign, .arp_slot, .arp_addr);

   // Clock and a cycle ceiling that cuts a hang short.
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end

   // Compares each result seen at the outputs with the oldest note.
   always @(negedge core_clk)
   begin
      if (s_axi_bvalid && s_axi_bready)
         pop("bresp", {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready && rchk)
         pop("read", {s_axi_rresp, s_axi_rdata});
      if ({smb_ack, smb_nack} != 2'h0 && {smb_ack, smb_nack} !== sp)
         pop("smbus", {32'hC000_0000, smb_ack, smb_nack});
      sp = {smb_ack, smb_nack};
      if (to_mp || to_host)
         pop("packet", {32'h4000_0000, to_mp, to_host});
   end

   task automatic pop(input string n, input logic [33:0] g);
      logic [33:0] e;
      e = q.size() ? q.pop_front() : 'x;
      `CHK(n, e, g)
   endtask

   // Bus write: address and data offered together, each dropped once taken.
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta;
      logic tw;
      q.push_back({r, 32'h0});
      {ta, tw} = 2'h0;
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(negedge core_clk);
         ta = ta | s_axi_awready;
         tw = tw | s_axi_wready;
         @(posedge core_clk);
         {s_axi_awvalid, s_axi_wvalid} <= {!ta, !tw};
      end
      while (!(ta && tw));
      do
         @(negedge core_clk);
      while (!s_axi_bvalid);
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask

   // Bus read; c selects whether the answer is checked against e.
   task automatic rd(input logic [15:0] a, input logic c, input logic [33:0] e);
      if (c)
         q.push_back(e);
      rchk = c;
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
         @(negedge core_clk);
      while (!s_axi_arready);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      do
         @(negedge core_clk);
      while (!s_axi_rvalid);
      rd_d = s_axi_rdata;
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic mcu(input logic [4:0] s, input logic [7:0] d);
      u_spg_mp_model.drive(s, d);
   endtask

   // Re-initializes with new image flags and fragment size, then polls for ready.
   task automatic ini(input logic v, input logic p, input logic [7:0] s);
      @(posedge core_clk);
      {image_valid, image_passthru, cfg_frag_size, init_req} <= {v, p, s, 1'b1};
      @(posedge core_clk);
      init_req <= 1'b0;
      used = 0;
      do
         rd(spg_pkg::POOL_STAT_OFS, 1'b0, 34'h0);
      while (!rd_d[30]);
   endtask

   // Sends one random packet and notes where it must go.
   task automatic pk;
      logic [7:0]  h;
      logic [15:0] pt;
      logic        hm, u, ok, fm, ho;
      h = 8'($urandom);
      {hm, u, ok} = 3'($urandom);
      pt = $urandom_range(1) ? spg_pkg::RMCP_PORT : 16'($urandom);
      fm = ctl[17] && (h & ctl[7:0]) != 8'h00 && (!ctl[8] || ok) && used < nb;
      ho = hm || (ctl[21] && (h & ctl[7:0]) != 8'h00);
      if (u && pt == spg_pkg::RMCP_PORT && ctl[10] && !ctl[9])
         ho = 1'b0;
      if (fm)
         used++;
      if (fm || ho)
         q.push_back({32'h4000_0000, fm, ho});
      @(posedge core_clk);
      {pkt_valid, pkt_filter_hit, pkt_dst_port} <= {1'b1, h, pt};
      {pkt_host_match, pkt_is_udp, pkt_csum_ok} <= {hm, u, ok};
      @(posedge core_clk);
      pkt_valid <= 1'b0;
   endtask

   task automatic test_done;
      if (q.size() != 0)
         error_cnt++;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      {core_clk, nrst, init_req, image_valid, image_passthru, rchk, sp, ctl} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cfg_frag_size} = '0;
      {pkt_valid, pkt_filter_hit, pkt_host_match, pkt_is_udp, pkt_dst_port, pkt_csum_ok} = '0;
      void'($urandom(23801));
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      rd(spg_pkg::MGMT_CTRL_OFS, 1'b1, 34'h0);
      rd(16'h0100, 1'b1, 34'h2_0000_0000);
      wr(16'h0100, 32'hFFFF_FFFF, 2'h2);
      wr(spg_pkg::MGMT_CTRL_OFS, 32'hFFFF_FFFF, 2'h0);
      rd(spg_pkg::MGMT_CTRL_OFS, 1'b1, {2'h0, spg_pkg::MGMT_CTRL_WMASK});
      for (int i = 0; i < 3; i++)
      begin
         ini(i[0], i[1], 8'hF0);
         q.push_back(NAK);
         mcu(ST, 8'h49);
         mcu(SP, 8'h00);
      end
      ini(1'b1, 1'b1, 8'hF0);
      nb = 12;
      rd(spg_pkg::SMB_ADDR_OFS, 1'b1, 34'h0_00F0_4A49);
      rd(spg_pkg::POOL_STAT_OFS, 1'b1, 34'h0_C00C_0000);
      mcu(ST, 8'h22);
      mcu(SP, 8'h00);
      mcu(AS, 8'hB3);
      q.push_back(ACK);
      mcu(ST, 8'h33);
      mcu(SP, 8'h00);
      mcu(ST, 8'h4A);
      mcu(SP, 8'h00);
      mcu(AS, 8'h4A);
      q.push_back(ACK);
      mcu(ST, 8'h4A);
      repeat (12) mcu(FR, 8'h20);
      q.push_back(NAK);
      mcu(FR, 8'h20);
      mcu(SP, 8'h00);
      rd(spg_pkg::POOL_STAT_OFS, 1'b1, 34'h0_C00C_000C);
      repeat (12) mcu(RL, 8'h00);
      q.push_back(ACK);
      mcu(ST, 8'h4A);
      mcu(FR, 8'hF0);
      q.push_back(NAK);
      mcu(FR, 8'hF1);
      mcu(SP, 8'h00);
      used = 1;
      for (int r = 0; r < 9; r++)
      begin
         ctl = (r == 8) ? 32'h0002_00FF : $urandom & spg_pkg::MGMT_CTRL_WMASK;
         wr(spg_pkg::MGMT_CTRL_OFS, ctl, 2'h0);
         repeat (r == 8 ? 14 : 6) pk();
      end
      q.push_back(ACK);
      mcu(ST, 8'h4A);
      if (used >= nb)
         q.push_back(NAK);
      mcu(FR, 8'h20);
      mcu(SP, 8'h00);
      @(posedge core_clk);
      cfg_frag_size <= 8'h00;
      rd(spg_pkg::SMB_ADDR_OFS, 1'b1, 34'h0_00F0_334A);
      ini(1'b1, 1'b1, 8'h00);
      rd(spg_pkg::POOL_STAT_OFS, 1'b1, 34'h0_C060_0000);
      test_done();
   end
endmodule
